//--- logic/gpt_pkg.sv
// Purpose: Constants, register map and state type for the timer group.
// Assumes: 32-bit register port with byte addresses; one word per register.
// Notes:   Each control, count and period register has clear, set and invert aliases at +0x4, +0x8, +0xC.
package gpt_pkg;
  localparam int GPT_AW = 12;
  localparam int GPT_DW = 32;
  localparam int GPT_NB = 4;

  // Register byte addresses.
  localparam logic [11:0] GPT_A_CTRL    = 12'h000;
  localparam logic [11:0] GPT_A_COUNT   = 12'h010;
  localparam logic [11:0] GPT_A_PERIOD  = 12'h020;
  localparam logic [11:0] GPT_B_BASE    = 12'h100;
  localparam logic [11:0] GPT_B_STRIDE  = 12'h040;
  localparam logic [11:0] GPT_B_CNT_OFS = 12'h010;
  localparam logic [11:0] GPT_B_PR_OFS  = 12'h020;
  localparam logic [11:0] GPT_STATUS    = 12'h200;
  localparam logic [11:0] GPT_ALIAS_MSK = 12'h00C;

  // Alias selector in address bits 3:2.
  localparam logic [1:0] GPT_OP_WR  = 2'h0;
  localparam logic [1:0] GPT_OP_CLR = 2'h1;
  localparam logic [1:0] GPT_OP_SET = 2'h2;
  localparam logic [1:0] GPT_OP_INV = 2'h3;

  // Control field positions.
  localparam int GPT_ON    = 15;
  localparam int GPT_IDLE_HALT = 13;
  localparam int GPT_WR_BLOCK  = 12;
  localparam int GPT_WR_PEND   = 11;
  localparam int GPT_GATE_EN   = 7;
  localparam int GPT_PS_HI = 5;
  localparam int GPT_PS_LO = 4;
  localparam int GPT_WIDE  = 3;
  localparam int GPT_TSYNC = 2;
  localparam int GPT_CLK_SEL = 1;

  // Writable bits of each control register.
  localparam logic [15:0] GPT_A_CTRL_WMSK  = 16'hB0B6;
  localparam logic [15:0] GPT_B_EVEN_WMSK  = 16'hA0BA;
  localparam logic [15:0] GPT_B_ODD_WMSK   = 16'hA0B2;
  localparam logic [15:0] GPT_CTRL_RST     = 16'h0000;
  localparam logic [15:0] GPT_PERIOD_RST   = 16'hFFFF;

  // Last prescaler count for divide by 1, 8, 64 and 256.
  localparam logic [7:0] GPT_DIV1_LAST   = 8'h00;
  localparam logic [7:0] GPT_DIV8_LAST   = 8'h07;
  localparam logic [7:0] GPT_DIV64_LAST  = 8'h3F;
  localparam logic [7:0] GPT_DIV256_LAST = 8'hFF;

  // Clock cycles an asynchronous count write stays pending.
  localparam int GPT_ASYNC_WR_CYCLES = 2;

  typedef struct packed {
    logic [15:0]                a_ctrl;
    logic [15:0]                a_cnt;
    logic [15:0]                a_pr;
    logic [15:0]                a_wdata;
    logic [7:0]                 a_wcnt;
    logic                       a_pend;
    logic [7:0]                 a_psc;
    logic                       a_ext_q;
    logic [GPT_NB-1:0][15:0]    b_ctrl;
    logic [GPT_NB-1:0][15:0]    b_cnt;
    logic [GPT_NB-1:0][15:0]    b_pr;
    logic [GPT_NB-1:0][7:0]     b_psc;
    logic [GPT_NB-1:0]          b_ext_q;
    logic [GPT_NB:0]            sticky;
    logic [GPT_NB:0]            match;
    logic [1:0]                 tbase;
    logic                       adc_trig;
    logic [31:0]                rdata;
  } gpt_state_type;
endpackage

//--- logic/gpt_timer_group.sv
// Purpose: One type-A timer and four pairable type-B timers behind a register port.
// Assumes: Pins are synchronous to mclk; external clocks count on rising edges.
// Notes:   Gated mode uses the external pin of the timer as its gate level.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps

// Functional notes
// - Write-block drops count writes while one pending.
// - Pending flag reads one during asynchronous write.
// - Pending flag reads zero in synchronous mode.
// - Gate enable ignored with external clock selected.
// - Internal clock plus gate counts only gate-high.
// - Prescale codes divide by 1, 8, 64, 256.
// - Four independent 16-bit type-B timers by default.
// - Type-B modes: internal, gated internal, external.
// - Timers two/three and four/five pair to 32-bit.
// - Wide-mode bit joins pair into one counter.
// - Wide-mode bit exists only on even timers.
// - Odd timer controls ignored in wide mode.
// - Clock select picks external pin or internal clock.
// - Only timers two and three give time base.
// - Only timer three triggers the converter.
// - Timers may keep running in CPU idle.
// - Clear, set and invert aliases for registers.
// - On bit fifteen enables or disables timer.
// - Halt-when-idle bit stops timer in idle.
// - Aliases at plus 0x4, 0x8, 0xC.
module gpt_timer_group #(
  parameter int unsigned ASYNC_WR_CYCLES = gpt_pkg::GPT_ASYNC_WR_CYCLES
) (
  // Clock and reset.
  input  wire logic                        mclk,
  input  wire logic                        nrst,
  // Register port.
  input  wire logic [gpt_pkg::GPT_AW-1:0]  reg_addr,
  input  wire logic [gpt_pkg::GPT_DW-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [gpt_pkg::GPT_DW-1:0]  reg_rdata,
  // Pins and system state.
  input  wire logic                        a_ext_pin,
  input  wire logic [gpt_pkg::GPT_NB-1:0]  b_ext_pin,
  input  wire logic                        cpu_idle,
  // Events.
  output logic      [gpt_pkg::GPT_NB:0]    period_match,
  output logic      [1:0]                  timebase_tick,
  output logic                             adc_trigger
);
  import gpt_pkg::*;

  // The wait counter is eight bits wide, so longer waits cannot be served.
  if (ASYNC_WR_CYCLES < 1 || ASYNC_WR_CYCLES > 255) begin : g_wait_range
    $error("ASYNC_WR_CYCLES must lie in 1..255");
  end

  gpt_state_type s;
  gpt_state_type next_s;

  function automatic logic [15:0] alias_apply(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [1:0] op);
    case (op)
      GPT_OP_CLR: alias_apply = old & ~wd;
      GPT_OP_SET: alias_apply = old | wd;
      GPT_OP_INV: alias_apply = old ^ wd;
      default:    alias_apply = wd;
    endcase
  endfunction

  function automatic logic [7:0] div_last(input logic [1:0] sel);
    case (sel)
      2'h3:    div_last = GPT_DIV256_LAST;
      2'h2:    div_last = GPT_DIV64_LAST;
      2'h1:    div_last = GPT_DIV8_LAST;
      default: div_last = GPT_DIV1_LAST;
    endcase
  endfunction

  // External clock counts rising edges; gating holds while the pin is low.
  function automatic logic src_event(input logic [15:0] ctrl, input logic pin, input logic q);
    if (ctrl[GPT_CLK_SEL]) begin
      src_event = pin & ~q;
    end else if (ctrl[GPT_GATE_EN]) begin
      src_event = pin;
    end else begin
      src_event = 1'b1;
    end
  endfunction

  function automatic logic timer_runs(input logic [15:0] ctrl, input logic idle);
    timer_runs = ctrl[GPT_ON] && !(ctrl[GPT_IDLE_HALT] && idle);
  endfunction

  logic                   a_async;
  logic [11:0]            base_addr;
  logic [1:0]             op;
  logic [GPT_NB-1:0]      b_wide_even;
  logic                   bus_cnt_wr;

  assign a_async     = s.a_ctrl[GPT_CLK_SEL] && !s.a_ctrl[GPT_TSYNC];
  assign base_addr   = reg_addr & ~GPT_ALIAS_MSK;
  assign op          = reg_addr[3:2];
  assign bus_cnt_wr  = reg_wr && (base_addr == GPT_A_COUNT);

  always_comb begin
    for (int k = 0; k < GPT_NB; k++) begin
      b_wide_even[k] = s.b_ctrl[k & 2][GPT_WIDE];
    end
  end

  always_comb begin
    logic             a_tick;
    logic [GPT_NB-1:0] b_tick;
    logic [15:0]      wd;
    logic [15:0]      val;
    logic [31:0]      wide_cnt;
    logic [31:0]      rd;
    logic [GPT_NB:0]  clr;
    int               c;
    int               e;
    int               o;
    a_tick   = 1'b0;
    b_tick   = '0;
    wd       = reg_wdata[15:0];
    val      = 16'h0000;
    wide_cnt = 32'h0000_0000;
    rd       = 32'h0000_0000;
    clr      = '0;
    c        = 0;
    e        = 0;
    o        = 0;
    next_s          = s;
    next_s.match    = '0;
    next_s.a_ext_q  = a_ext_pin;
    next_s.b_ext_q  = b_ext_pin;

    // Type-A prescaler and counter; the gate term vanishes when the pin is the clock.
    if (!s.a_ctrl[GPT_ON]) begin
      next_s.a_psc = 8'h00;
    end else if (timer_runs(s.a_ctrl, cpu_idle) &&
                 src_event(s.a_ctrl, a_ext_pin, s.a_ext_q)) begin
      if (s.a_psc >= div_last(s.a_ctrl[GPT_PS_HI:GPT_PS_LO])) begin
        next_s.a_psc = 8'h00;
        a_tick       = 1'b1;
      end else begin
        next_s.a_psc = s.a_psc + 8'h01;
      end
    end
    if (a_tick) begin
      if (s.a_cnt == s.a_pr) begin
        next_s.a_cnt    = 16'h0000;
        next_s.match[0] = 1'b1;
      end else begin
        next_s.a_cnt = s.a_cnt + 16'h0001;
      end
    end
    if (s.a_pend) begin
      if (s.a_wcnt <= 8'h01) begin
        next_s.a_pend = 1'b0;
        next_s.a_cnt  = s.a_wdata;
      end else begin
        next_s.a_wcnt = s.a_wcnt - 8'h01;
      end
    end

    // Type-B prescalers; an odd timer in wide mode follows its even partner.
    for (int i = 0; i < GPT_NB; i++) begin
      c = (i % 2 == 1 && b_wide_even[i]) ? i - 1 : i;
      if (c != i || !s.b_ctrl[i][GPT_ON]) begin
        next_s.b_psc[i] = 8'h00;
      end else if (timer_runs(s.b_ctrl[i], cpu_idle) &&
                   src_event(s.b_ctrl[i], b_ext_pin[i], s.b_ext_q[i])) begin
        if (s.b_psc[i] >= div_last(s.b_ctrl[i][GPT_PS_HI:GPT_PS_LO])) begin
          next_s.b_psc[i] = 8'h00;
          b_tick[i]       = 1'b1;
        end else begin
          next_s.b_psc[i] = s.b_psc[i] + 8'h01;
        end
      end
    end

    // Type-B counters, alone or paired; a wide match is signalled on the odd timer.
    for (int p = 0; p < GPT_NB / 2; p++) begin
      e = 2 * p;
      o = 2 * p + 1;
      if (s.b_ctrl[e][GPT_WIDE]) begin
        if (b_tick[e]) begin
          if ({s.b_cnt[o], s.b_cnt[e]} == {s.b_pr[o], s.b_pr[e]}) begin
            wide_cnt          = 32'h0000_0000;
            next_s.match[o+1] = 1'b1;
          end else begin
            wide_cnt = {s.b_cnt[o], s.b_cnt[e]} + 32'h0000_0001;
          end
          next_s.b_cnt[e] = wide_cnt[15:0];
          next_s.b_cnt[o] = wide_cnt[31:16];
        end
      end else begin
        for (int j = e; j <= o; j++) begin
          if (b_tick[j]) begin
            if (s.b_cnt[j] == s.b_pr[j]) begin
              next_s.b_cnt[j]   = 16'h0000;
              next_s.match[j+1] = 1'b1;
            end else begin
              next_s.b_cnt[j] = s.b_cnt[j] + 16'h0001;
            end
          end
        end
      end
    end
    next_s.tbase    = {b_tick[1] | (b_tick[0] & b_wide_even[1]), b_tick[0]};
    next_s.adc_trig = next_s.match[2];

    // Register writes, through the plain address or one of its aliases.
    if (reg_wr) begin
      if (base_addr == GPT_A_CTRL) begin
        val           = alias_apply(s.a_ctrl, wd, op);
        next_s.a_ctrl = val & GPT_A_CTRL_WMSK;
      end else if (base_addr == GPT_A_COUNT) begin
        val = alias_apply(s.a_cnt, wd, op);
        if (!a_async) begin
          next_s.a_cnt = val;
        end else if (!(s.a_pend && s.a_ctrl[GPT_WR_BLOCK])) begin
          next_s.a_pend  = 1'b1;
          next_s.a_wcnt  = 8'(ASYNC_WR_CYCLES);
          next_s.a_wdata = val;
        end
      end else if (base_addr == GPT_A_PERIOD) begin
        next_s.a_pr = alias_apply(s.a_pr, wd, op);
      end else if (base_addr == GPT_STATUS) begin
        if (op == GPT_OP_WR || op == GPT_OP_CLR) begin
          clr = reg_wdata[GPT_NB:0];
        end
      end
      for (int i = 0; i < GPT_NB; i++) begin
        if (base_addr == GPT_B_BASE + 12'(i) * GPT_B_STRIDE) begin
          val = alias_apply(s.b_ctrl[i], wd, op);
          next_s.b_ctrl[i] = val & ((i % 2 == 0) ? GPT_B_EVEN_WMSK : GPT_B_ODD_WMSK);
        end else if (base_addr == GPT_B_BASE + 12'(i) * GPT_B_STRIDE + GPT_B_CNT_OFS) begin
          next_s.b_cnt[i] = alias_apply(s.b_cnt[i], wd, op);
        end else if (base_addr == GPT_B_BASE + 12'(i) * GPT_B_STRIDE + GPT_B_PR_OFS) begin
          next_s.b_pr[i] = alias_apply(s.b_pr[i], wd, op);
        end
      end
    end
    // A match in the same cycle as its clear keeps the flag set.
    next_s.sticky = (s.sticky & ~clr) | next_s.match;

    // Reads answer next cycle; aliases and unmapped addresses read zero.
    if (reg_rd && op == GPT_OP_WR) begin
      if (reg_addr == GPT_A_CTRL) begin
        rd = {16'h0000, s.a_ctrl};
        rd[GPT_WR_PEND] = s.a_pend && a_async;
      end else if (reg_addr == GPT_A_COUNT) begin
        rd = {16'h0000, s.a_cnt};
      end else if (reg_addr == GPT_A_PERIOD) begin
        rd = {16'h0000, s.a_pr};
      end else if (reg_addr == GPT_STATUS) begin
        rd = 32'(s.sticky);
      end
      for (int i = 0; i < GPT_NB; i++) begin
        if (reg_addr == GPT_B_BASE + 12'(i) * GPT_B_STRIDE) begin
          rd = {16'h0000, s.b_ctrl[i]};
        end else if (reg_addr == GPT_B_BASE + 12'(i) * GPT_B_STRIDE + GPT_B_CNT_OFS) begin
          rd = {16'h0000, s.b_cnt[i]};
        end else if (reg_addr == GPT_B_BASE + 12'(i) * GPT_B_STRIDE + GPT_B_PR_OFS) begin
          rd = {16'h0000, s.b_pr[i]};
        end
      end
    end
    next_s.rdata = rd;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s        <= '0;
      s.a_pr   <= GPT_PERIOD_RST;
      s.b_pr   <= {GPT_NB{GPT_PERIOD_RST}};
      s.a_ctrl <= GPT_CTRL_RST;
      s.b_ctrl <= {GPT_NB{GPT_CTRL_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata     = s.rdata;
  assign period_match  = s.match;
  assign timebase_tick = s.tbase;
  assign adc_trigger   = s.adc_trig;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_blocked_drop: assert property (s.a_pend && s.a_ctrl[GPT_WR_BLOCK] && s.a_wcnt > 8'h01
                                   && bus_cnt_wr |=> s.a_wdata == $past(s.a_wdata))
    else $error("Blocked asynchronous write was taken");
  a_pend_done: assert property (s.a_pend && s.a_wcnt == 8'h01 && !bus_cnt_wr
                                |=> !s.a_pend && s.a_cnt == $past(s.a_wdata))
    else $error("Pending write did not complete");
  a_pend_read: assert property (reg_rd && reg_addr == GPT_A_CTRL && a_async && s.a_pend
                                |=> reg_rdata[GPT_WR_PEND])
    else $error("Pending flag read zero while pending");
  a_pend_sync: assert property (reg_rd && reg_addr == GPT_A_CTRL && !a_async
                                |=> !reg_rdata[GPT_WR_PEND])
    else $error("Pending flag set in synchronous mode");
  a_gate_hold: assert property (s.a_ctrl[GPT_ON] && !s.a_ctrl[GPT_CLK_SEL] &&
                                s.a_ctrl[GPT_GATE_EN] && !a_ext_pin && !s.a_pend && !reg_wr
                                |=> $stable(s.a_psc) && $stable(s.a_cnt))
    else $error("Gated timer advanced with gate low");
  a_presc_range: assert property (timer_runs(s.a_ctrl, cpu_idle) &&
                                  src_event(s.a_ctrl, a_ext_pin, s.a_ext_q) &&
                                  s.a_psc >= div_last(s.a_ctrl[GPT_PS_HI:GPT_PS_LO])
                                  |=> s.a_psc == 8'h00)
    else $error("Prescaler did not wrap at its divide ratio");
  a_off_hold: assert property (!s.b_ctrl[0][GPT_ON] && !reg_wr ##1 !reg_wr
                               |-> $stable(s.b_cnt[0]))
    else $error("Disabled timer counted");
  a_idle_halt: assert property (s.b_ctrl[2][GPT_IDLE_HALT] && cpu_idle && !reg_wr
                                |=> $stable(s.b_cnt[2]) && $stable(s.b_psc[2]))
    else $error("Timer ran in idle with halt set");
  a_wide_carry: assert property (s.b_ctrl[0][GPT_WIDE] && !reg_wr &&
                                 $past(s.b_cnt[0]) != 16'hFFFF && s.b_cnt[0] != 16'h0000
                                 |-> s.b_cnt[1] == $past(s.b_cnt[1]) || $past(reg_wr))
    else $error("Upper half moved without carry");
  a_adc_src: assert property (adc_trigger |-> period_match[2])
    else $error("Converter trigger without timer three match");
  a_match_flag: assert property (period_match[1] |-> s.sticky[1])
    else $error("Match event not recorded");

  c_async_done: cover property (s.a_pend ##1 !s.a_pend);
  c_wide_match: cover property (s.b_ctrl[0][GPT_WIDE] && period_match[2]);
  c_adc_fire:   cover property (adc_trigger);
  c_gated_tick: cover property (s.b_ctrl[1][GPT_GATE_EN] && period_match[2]);
endmodule

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the timer group, driven through its register port.
// Assumes: Every task starts and ends 1 ns after a rising edge of mclk.
// Notes:   An async write wait of three cycles, one more than the default, is used so that back-to-back cases stay pending.
`timescale 1ns/1ps
module tb_top;
  import gpt_pkg::*;
  localparam int WR_WAIT = 3;
  logic        mclk        = 1'b0;
  logic        nrst        = 1'b0;
  logic [11:0] reg_addr    = 12'h000;
  logic [31:0] reg_wdata   = 32'h0;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [31:0] reg_rdata;
  logic        a_ext_pin   = 1'b0;
  logic        a_tog       = 1'b0;
  logic        a_lvl       = 1'b0;
  logic [3:0]  b_ext_pin   = 4'h0;
  logic [3:0]  b_tog       = 4'h0;
  logic [3:0]  b_lvl       = 4'h0;
  logic        cpu_idle    = 1'b0;
  logic [4:0]  period_match;
  logic [1:0]  timebase_tick;
  logic        adc_trigger;
  int          err_total    = 0;
  int          total_checks = 0;
  int          seed         = 32'h7633;
  int          pm_cnt[5];
  int          tb_cnt[2];
  int          adc_cnt;
  int          divs[4]      = '{1, 8, 64, 256};

  gpt_timer_group #(.ASYNC_WR_CYCLES(WR_WAIT)) dut (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .a_ext_pin(a_ext_pin),
    .b_ext_pin(b_ext_pin), .cpu_idle(cpu_idle), .period_match(period_match),
    .timebase_tick(timebase_tick), .adc_trigger(adc_trigger)
  );

  initial begin
    forever #5 mclk = ~mclk;
  end

  // Pins either toggle every cycle, giving a rising edge every second cycle, or hold a level.
  always @(posedge mclk) begin
    a_ext_pin <= a_tog ? ~a_ext_pin : a_lvl;
    b_ext_pin <= (b_tog & ~b_ext_pin) | (~b_tog & b_lvl);
  end

  function automatic logic [11:0] bctl(input int i);
    return GPT_B_BASE + 12'(GPT_B_STRIDE * i);
  endfunction

  function automatic logic [15:0] apply(input logic [15:0] v, input logic [1:0] op,
                                        input logic [15:0] d, input logic [15:0] m);
    case (op)
      GPT_OP_WR:  return d & m;
      GPT_OP_CLR: return v & ~(d & m);
      GPT_OP_SET: return v | (d & m);
      default:    return v ^ (d & m);
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset();
    nrst     <= 1'b0;
    a_tog    <= 1'b0;
    a_lvl    <= 1'b0;
    b_tog    <= 4'h0;
    b_lvl    <= 4'h0;
    cpu_idle <= 1'b0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    #1;
  endtask

  // Interval between two successive pulses, bounded so a silent timer cannot hang the run.
  task automatic meas(input int b, input int e, input string nm);
    int n;
    n = 0;
    while (period_match[b] !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (period_match[b] !== 1'b1 && n < 3000);
    chk(nm, e, n);
  endtask

  task automatic watch(input int n);
    pm_cnt  = '{0, 0, 0, 0, 0};
    tb_cnt  = '{0, 0};
    adc_cnt = 0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      for (int b = 0; b < 5; b++) pm_cnt[b] += (period_match[b] === 1'b1);
      for (int b = 0; b < 2; b++) tb_cnt[b] += (timebase_tick[b] === 1'b1);
      adc_cnt += (adc_trigger === 1'b1);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #300_000;
    err_total++;
    $display("[FAIL] watchdog expected end of tests seen hang");
    give_verdict();
  end

  initial begin
    logic [11:0] a;
    logic [15:0] m;
    logic [15:0] v;
    logic [1:0]  op;
    logic [31:0] d;
    int          p;
    do_reset();
    rdc("a_ctrl_rst", GPT_A_CTRL, 32'h0);
    rdc("a_period_rst", GPT_A_PERIOD, 32'h0000FFFF);
    rdc("b_count_rst", bctl(3) + GPT_B_CNT_OFS, 32'h0);
    rdc("unmapped_read", 12'h300, 32'h0);
    // Control words and one period under random plain and alias writes.
    for (int r = 0; r < 6; r++) begin
      a = (r == 0) ? GPT_A_CTRL : (r == 5) ? GPT_A_PERIOD : bctl(r - 1);
      m = (r == 0) ? GPT_A_CTRL_WMSK : (r == 5) ? 16'hFFFF :
          (r % 2 == 1) ? GPT_B_EVEN_WMSK : GPT_B_ODD_WMSK;
      v = (r == 5) ? GPT_PERIOD_RST : GPT_CTRL_RST;
      for (int k = 0; k < 8; k++) begin
        op = (k == 0) ? GPT_OP_WR : 2'($random(seed));
        d  = (k == 0) ? 32'hFFFFFFFF : $random(seed);
        wr(a | {8'h00, op, 2'b00}, d);
        v = apply(v, op, d[15:0], m);
        rdc("ctrl_alias", a, {16'h0000, v});
      end
      rdc("alias_read", a | 12'h004, 32'h0);
    end
    for (int c = 0; c < 4; c++) begin
      do_reset();
      wr(GPT_A_PERIOD, 32'h1);
      wr(GPT_A_CTRL, 32'h8000 | (c << 4));
      meas(0, 2 * divs[c], "a_prescale");
    end
    wr(GPT_A_CTRL, 32'h0);
    watch(600);
    chk("a_off_matches", 32'h0, pm_cnt[0]);
    do_reset();
    wr(GPT_A_PERIOD, 32'h3);
    wr(GPT_A_CTRL, 32'h8080);
    watch(40);
    chk("a_gate_low", 32'h0, pm_cnt[0]);
    a_lvl <= 1'b1;
    meas(0, 4, "a_gate_high");
    a_lvl <= 1'b0;
    a_tog <= 1'b1;
    wr(GPT_A_CTRL, 32'h8086);
    meas(0, 8, "a_ext_gate_ignored");
    for (int i = 0; i < 4; i++) begin
      do_reset();
      p = 2 + ($random(seed) & 15);
      wr(bctl(i) + GPT_B_PR_OFS, p);
      wr(bctl(i), 32'h8080);
      watch(40);
      chk("b_gate_low", 32'h0, pm_cnt[i + 1]);
      b_lvl[i] <= 1'b1;
      meas(i + 1, p + 1, "b_gate_high");
      b_lvl[i] <= 1'b0;
      b_tog[i] <= 1'b1;
      wr(bctl(i), 32'h8002);
      meas(i + 1, 2 * (p + 1), "b_ext_clock");
      b_tog[i] <= 1'b0;
      wr(bctl(i), 32'h8000);
      meas(i + 1, p + 1, "b_internal");
      watch(40);
      chk("tbase_t2", (i == 0) ? 40 : 0, tb_cnt[0]);
      chk("tbase_t3", (i == 1) ? 40 : 0, tb_cnt[1]);
      chk("adc_trig", (i == 1) ? pm_cnt[2] : 0, adc_cnt);
    end
    do_reset();
    wr(bctl(0) + GPT_B_PR_OFS, 32'h4);
    wr(bctl(0), 32'h8000);
    cpu_idle <= 1'b1;
    meas(1, 5, "run_in_idle");
    wr(bctl(0), 32'hA000);
    watch(30);
    chk("halt_in_idle", 32'h0, pm_cnt[1]);
    cpu_idle <= 1'b0;
    meas(1, 5, "resume_after_idle");
    // Wide pair: 0000FFF0 reaches period 00010000 only if the carry crosses halves.
    do_reset();
    wr(bctl(0) + GPT_B_CNT_OFS, 32'hFFF0);
    wr(bctl(0) + GPT_B_PR_OFS, 32'h0);
    wr(bctl(1) + GPT_B_PR_OFS, 32'h1);
    wr(bctl(1), 32'h0002);
    wr(bctl(0), 32'h8008);
    watch(40);
    chk("wide_match", 32'h1, pm_cnt[2]);
    chk("wide_even_quiet", 32'h0, pm_cnt[1]);
    chk("wide_adc", 32'h1, adc_cnt);
    rdc("status_wide", GPT_STATUS, 32'h4);
    wr(GPT_STATUS, 32'h1F);
    rdc("status_clear", GPT_STATUS, 32'h0);
    do_reset();
    wr(GPT_A_CTRL, 32'h9002);
    wr(GPT_A_COUNT, 32'h1234);
    rdc("pending_set", GPT_A_CTRL, 32'h9802);
    wr(GPT_A_COUNT, 32'h5678);
    idle(6);
    rdc("blocked_write", GPT_A_COUNT, 32'h1234);
    rdc("pending_clear", GPT_A_CTRL, 32'h9002);
    wr(GPT_A_CTRL, 32'h8002);
    wr(GPT_A_COUNT, 32'h1111);
    wr(GPT_A_COUNT, 32'h2222);
    idle(6);
    rdc("back_to_back", GPT_A_COUNT, 32'h2222);
    wr(GPT_A_CTRL, 32'h8006);
    wr(GPT_A_COUNT, 32'h0055);
    rdc("sync_no_pending", GPT_A_CTRL, 32'h8006);
    rdc("sync_count", GPT_A_COUNT, 32'h0055);
    give_verdict();
  end
endmodule
